// ---- logic/responder_defs.svh ----
/*
 * Constants of the timing status packet responder: frame bytes, field
 * positions, register offsets, reset values and timing counts.
 * Assumes a 20 MHz pclk and a byte-wide serial path on the same clock.
 */
// Overview of operation
// R1 - Host asks for clock corrections with A1/02 frame, length two, mode zero.
// R2 - Length field in bytes 3-4 counts mode, payload, checksum; mode 2 answers.
// R3 - Byte 6 of clock answer: bit 0 reference, bits 1-4 offset valid.
// R4 - Week in bytes 7-8, seconds into week 9-12, capped at 604799.
// R5 - Bytes 13-16 of clock answer always hold single-precision zero.
// R6 - Four single-precision offsets occupy bytes 17 through 32.
// R7 - Answers end with checksum, 0x10, 0x03; bytes 33-35 for clock answer.
// R8 - Nine-byte A1/03 mode-zero query gets a mode-2 frequency answer.
// R9 - When enabled, frequency answer goes out once per second unasked.
// R10 - Frequency offset in ns/s sits in bytes 6-9 as single precision.
// R11 - Byte 10 gives converter bits 0 to 32; zero means synthesizer control.
// R12 - Byte 52 of frequency answer names the selected reference input.
// R13 - Clock corrections answered only while extra constellations are enabled.
`ifndef RESPONDER_DEFS_SVH
`define RESPONDER_DEFS_SVH

`define START_BYTE     8'h10
`define PKT_ID         8'ha1
`define SUB_CC         8'h02
`define SUB_FREQ       8'h03
`define MODE_QUERY     8'h00
`define MODE_RESP      8'h02
`define DELIM1         8'h10
`define DELIM2         8'h03
`define QUERY_LEN      16'h0002
`define CC_LEN         16'h001d
`define FREQ_LEN       16'h0031
`define QUERY_LAST     4'h8

`define CC_LAST        6'h23
`define FREQ_LAST      6'h37
`define CC_FLAGS_POS   6'h06
`define CC_WEEK_POS    6'h07
`define CC_SEC_POS     6'h09
`define CC_ZERO_POS    6'h0d
`define CC_OFS_POS     6'h11
`define CC_OFS_END     6'h20
`define FQ_OFS_POS     6'h06
`define FQ_DAC_POS     6'h0a
`define FQ_REF_POS     6'h34

`define MAX_SECONDS    32'h00093a7f
`define MAX_DAC_BITS   6'h20

`define REG_CTRL       12'h000
`define REG_FLAGS      12'h004
`define REG_WEEK       12'h008
`define REG_SECONDS    12'h00c
`define REG_OFS0       12'h010
`define REG_FREQ_OFS   12'h020
`define REG_DAC_SIZE   12'h024
`define REG_REF_INPUT  12'h028
`define REG_STATUS     12'h02c

`define CTRL_AUTO_BIT  0
`define CTRL_MULTI_BIT 1
`define CTRL_SCC_BIT   2
`define CTRL_SFQ_BIT   3
`define STAT_BUSY_BIT  0
`define STAT_FULL_BIT  1
`define STAT_REF_BIT   2

`define CTRL_RESET     2'h0
`define FIFO_WIDTH     8
`define FIFO_DEPTH     8

`define CLK_PERIOD_NS  50
`define AUTO_PERIOD_S  1

`endif

// ---- logic/responder_pkg.sv ----
/*
 * Types shared by the responder modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package responder_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01
    } build_state_t;

    typedef enum logic {
        KIND_CC   = 1'b0,
        KIND_FREQ = 1'b1
    } frame_kind_t;
endpackage

// ---- logic/byte_fifo.sv ----
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock, an active-low asynchronous reset and a clock enable.
 */
`timescale 1ns/1ns
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clk_en,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data  = mem[rd_ptr[AW-1:0]];
    assign push      = in_valid && in_ready && clk_en;
    assign pop       = out_valid && out_ready && clk_en;

    // Storage
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

// ---- logic/query_parser.sv ----
/*
 * Recognises the two nine-byte query frames in the received byte stream.
 * Assumes bytes arrive from a receiver on pclk, one per rx_valid pulse.
 */
`timescale 1ns/1ns
`include "responder_defs.svh"
module query_parser
    import responder_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clk_en,
    // Received bytes
    input  wire logic [7:0] rx_byte,
    input  wire logic       rx_valid,
    // Recognised queries
    output logic            query_cc,
    output logic            query_freq
);
    logic [3:0] pos;
    logic       is_freq;
    logic       ok;

    localparam logic [15:0] QLEN = `QUERY_LEN;

    // Expected byte at each position, see R1, see R8
    always_comb begin
        ok = 1'b0;
        unique case (pos)
            4'h0: ok = rx_byte == `START_BYTE;
            4'h1: ok = rx_byte == `PKT_ID;
            4'h2: ok = rx_byte == `SUB_CC || rx_byte == `SUB_FREQ;
            4'h3: ok = rx_byte == QLEN[15:8];
            4'h4: ok = rx_byte == QLEN[7:0];
            4'h5: ok = rx_byte == `MODE_QUERY;
            4'h6: ok = 1'b1;
            4'h7: ok = rx_byte == `DELIM1;
            4'h8: ok = rx_byte == `DELIM2;
            default: ok = 1'b0;
        endcase
    end

    // Position in frame; a stray start byte restarts the frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos     <= 4'h0;
            is_freq <= 1'b0;
        end else if (clk_en && rx_valid) begin
            if (ok && pos != `QUERY_LAST) begin
                pos <= pos + 4'h1;
            end else if (rx_byte == `START_BYTE && pos != 4'h0) begin
                pos <= 4'h1;
            end else begin
                pos <= 4'h0;
            end
            if (pos == 4'h2) begin
                is_freq <= rx_byte == `SUB_FREQ;
            end
        end
    end

    // One-cycle pulse at the final terminator byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            query_cc   <= 1'b0;
            query_freq <= 1'b0;
        end else if (clk_en) begin
            query_cc   <= rx_valid && ok && pos == `QUERY_LAST && !is_freq;
            query_freq <= rx_valid && ok && pos == `QUERY_LAST && is_freq;
        end
    end
endmodule

// ---- logic/timing_status_packet_responder.sv ----
/*
 * Builds clock-correction and frequency-information answer frames,
 * with an APB register file holding the reported values.
 * Assumes a 20 MHz pclk, a same-clock byte receiver and transmitter.
 */
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "responder_defs.svh"
module timing_status_packet_responder
    import responder_pkg::*;
#(
    parameter int unsigned SECOND_CYCLES =
        `AUTO_PERIOD_S * (1000000000 / `CLK_PERIOD_NS)
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Received byte stream
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_valid,
    // Transmitted byte stream
    output logic [7:0]       tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready
);
    // Registers
    logic [1:0]  ctrl;
    logic [4:0]  valid_flags;
    logic [15:0] week;
    logic [31:0] seconds_into_week;
    logic [31:0] cc_offset [4];
    logic [31:0] freq_offset;
    logic [5:0]  dac_size;
    logic [7:0]  ref_input;
    logic        refused;
    logic [7:0]  sent_count;

    // Builder state
    build_state_t state;
    frame_kind_t  kind;
    logic [5:0]   idx;
    logic [7:0]   csum;
    logic         pend_cc;
    logic         pend_freq;
    logic [24:0]  sec_cnt;
    logic         tick;

    // Internal nets
    logic        query_cc;
    logic        query_freq;
    logic        acc;
    logic        wr;
    logic        mapped;
    logic [31:0] rd_word;
    logic [7:0]  next_byte;
    logic [5:0]  last_idx;
    logic        push;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [7:0]  fifo_out_data;
    logic        sw_cc;
    logic        sw_freq;
    logic        start_cc;
    logic        start_freq;

    function automatic logic [7:0] be_byte(logic [31:0] w, logic [1:0] k);
        be_byte = w[(5'd31 - {k, 3'b000}) -: 8];
    endfunction

    function automatic logic [31:0] clamp(logic [31:0] v, logic [31:0] lim);
        clamp = (v > lim) ? lim : v;
    endfunction

    query_parser u_parser (
        .pclk       (pclk),
        .presetn    (presetn),
        .clk_en     (clk_en),
        .rx_byte    (rx_byte),
        .rx_valid   (rx_valid),
        .query_cc   (query_cc),
        .query_freq (query_freq)
    );

    // APB decode
    assign acc    = psel && penable && pready;
    assign wr     = acc && pwrite && mapped && clk_en;
    assign sw_cc  = wr && paddr == `REG_CTRL && pwdata[`CTRL_SCC_BIT];
    assign sw_freq = wr && paddr == `REG_CTRL && pwdata[`CTRL_SFQ_BIT];

    always_comb begin
        mapped  = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (paddr)
            `REG_CTRL:      rd_word = {30'h0, ctrl};
            `REG_FLAGS:     rd_word = {27'h0, valid_flags};
            `REG_WEEK:      rd_word = {16'h0, week};
            `REG_SECONDS:   rd_word = seconds_into_week;
            `REG_OFS0:      rd_word = cc_offset[0];
            12'h014:        rd_word = cc_offset[1];
            12'h018:        rd_word = cc_offset[2];
            12'h01c:        rd_word = cc_offset[3];
            `REG_FREQ_OFS:  rd_word = freq_offset;
            `REG_DAC_SIZE:  rd_word = {26'h0, dac_size};
            `REG_REF_INPUT: rd_word = {24'h0, ref_input};
            `REG_STATUS:    rd_word = {16'h0, sent_count, 5'h0, refused,
                                       !fifo_in_ready, state != ST_IDLE};
            default:        mapped = 1'b0;
        endcase
    end

    // APB answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            if (psel && penable && !pready && !pwrite) begin
                prdata <= rd_word;
            end
        end
    end

    // Software-written values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl              <= `CTRL_RESET;
            valid_flags       <= 5'h00;
            week              <= 16'h0000;
            seconds_into_week <= 32'h0000_0000;
            cc_offset         <= '{default: 32'h0000_0000};
            freq_offset       <= 32'h0000_0000;
            dac_size          <= 6'h00;
            ref_input         <= 8'h00;
        end else if (wr) begin
            unique case (paddr)
                `REG_CTRL:      ctrl <= pwdata[1:0];
                `REG_FLAGS:     valid_flags <= pwdata[4:0];      // see R3
                `REG_WEEK:      week <= pwdata[15:0];            // see R4
                `REG_SECONDS:   seconds_into_week <=
                                    clamp(pwdata, `MAX_SECONDS); // see R4
                `REG_OFS0:      cc_offset[0] <= pwdata;
                12'h014:        cc_offset[1] <= pwdata;
                12'h018:        cc_offset[2] <= pwdata;
                12'h01c:        cc_offset[3] <= pwdata;
                `REG_FREQ_OFS:  freq_offset <= pwdata;           // see R10
                `REG_DAC_SIZE:  dac_size <= 6'(clamp(pwdata,
                                    32'(`MAX_DAC_BITS)));        // see R11
                `REG_REF_INPUT: ref_input <= pwdata[7:0];        // see R12
                default: ;
            endcase
        end
    end

    // Refused clock-correction queries, set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refused <= 1'b0;
        end else if (clk_en) begin
            if (query_cc && !ctrl[`CTRL_MULTI_BIT]) begin
                refused <= 1'b1;                                  // see R13
            end else if (wr && paddr == `REG_STATUS
                         && pwdata[`STAT_REF_BIT]) begin
                refused <= 1'b0;
            end
        end
    end

    // Once-per-second tick while automatic output is enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_cnt <= 25'h0000000;
            tick    <= 1'b0;
        end else if (clk_en) begin
            tick <= 1'b0;
            if (!ctrl[`CTRL_AUTO_BIT]) begin
                sec_cnt <= 25'h0000000;
            end else if (sec_cnt == 25'(SECOND_CYCLES - 1)) begin
                sec_cnt <= 25'h0000000;
                tick    <= 1'b1;                                  // see R9
            end else begin
                sec_cnt <= sec_cnt + 25'h0000001;
            end
        end
    end

    // Pending answers; a new request wins over the clear at start
    assign start_cc   = state == ST_IDLE && pend_cc;
    assign start_freq = state == ST_IDLE && !pend_cc && pend_freq;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_cc   <= 1'b0;
            pend_freq <= 1'b0;
        end else if (clk_en) begin
            if ((query_cc || sw_cc) && ctrl[`CTRL_MULTI_BIT]) begin
                pend_cc <= 1'b1;                                  // see R13
            end else if (start_cc) begin
                pend_cc <= 1'b0;
            end
            if (query_freq || sw_freq
                || (tick && ctrl[`CTRL_AUTO_BIT])) begin
                pend_freq <= 1'b1;                           // see R8, see R9
            end else if (start_freq) begin
                pend_freq <= 1'b0;
            end
        end
    end

    // Frame contents
    assign last_idx = (kind == KIND_CC) ? `CC_LAST : `FREQ_LAST;
    assign push     = state == ST_SEND && fifo_in_ready && clk_en;

    always_comb begin
        logic [5:0]  rel;
        logic [15:0] len;
        rel       = 6'h00;
        len       = (kind == KIND_CC) ? `CC_LEN : `FREQ_LEN;
        next_byte = 8'h00;
        if (idx == 6'h00) begin
            next_byte = `START_BYTE;
        end else if (idx == 6'h01) begin
            next_byte = `PKT_ID;
        end else if (idx == 6'h02) begin
            next_byte = (kind == KIND_CC) ? `SUB_CC : `SUB_FREQ;
        end else if (idx == 6'h03) begin
            next_byte = len[15:8];                                // see R2
        end else if (idx == 6'h04) begin
            next_byte = len[7:0];
        end else if (idx == 6'h05) begin
            next_byte = `MODE_RESP;                               // see R2
        end else if (idx == last_idx - 6'h02) begin
            next_byte = csum;                                     // see R7
        end else if (idx == last_idx - 6'h01) begin
            next_byte = `DELIM1;
        end else if (idx == last_idx) begin
            next_byte = `DELIM2;
        end else if (kind == KIND_CC) begin
            if (idx == `CC_FLAGS_POS) begin
                next_byte = {3'h0, valid_flags};                  // see R3
            end else if (idx < `CC_SEC_POS) begin
                rel       = idx - `CC_WEEK_POS;
                next_byte = be_byte({week, 16'h0}, rel[1:0]);     // see R4
            end else if (idx < `CC_ZERO_POS) begin
                rel       = idx - `CC_SEC_POS;
                next_byte = be_byte(seconds_into_week, rel[1:0]);
            end else if (idx >= `CC_OFS_POS) begin    // 13-16 zero, see R5
                rel       = idx - `CC_OFS_POS;
                next_byte = be_byte(cc_offset[rel[3:2]], rel[1:0]); // see R6
            end
        end else begin
            if (idx < `FQ_DAC_POS) begin
                rel       = idx - `FQ_OFS_POS;
                next_byte = be_byte(freq_offset, rel[1:0]);       // see R10
            end else if (idx == `FQ_DAC_POS) begin
                next_byte = {2'h0, dac_size};                     // see R11
            end else if (idx == `FQ_REF_POS) begin
                next_byte = ref_input;                            // see R12
            end
        end
    end

    // Frame builder sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= ST_IDLE;
            kind       <= KIND_CC;
            idx        <= 6'h00;
            csum       <= 8'h00;
            sent_count <= 8'h00;
        end else if (clk_en) begin
            unique case (state)
                ST_IDLE: begin
                    idx  <= 6'h00;
                    csum <= 8'h00;
                    if (start_cc || start_freq) begin
                        kind  <= start_cc ? KIND_CC : KIND_FREQ;
                        state <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (push) begin
                        idx <= idx + 6'h01;
                        if (idx != 6'h00 && idx < last_idx - 6'h02) begin
                            csum <= csum ^ next_byte;             // see R7
                        end
                        if (idx == last_idx) begin
                            state      <= ST_IDLE;
                            sent_count <= sent_count + 8'h01;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    byte_fifo #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .in_valid  (state == ST_SEND),
        .in_ready  (fifo_in_ready),
        .in_data   (next_byte),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // Output byte register
    assign fifo_out_ready = !tx_valid || tx_ready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_valid <= 1'b0;
            tx_data  <= 8'h00;
        end else if (clk_en && fifo_out_ready) begin
            tx_valid <= fifo_out_valid;
            tx_data  <= fifo_out_data;
        end
    end

    // Checks
    AST_MODE_RESP: assert property (@(posedge pclk)           // see R2
        disable iff (!presetn) push && idx == 6'h05 |-> next_byte == 8'h02)
        else $error("Answer mode byte is not 2");
    AST_CC_LEN: assert property (@(posedge pclk)              // see R2
        disable iff (!presetn) push && kind == KIND_CC && idx == 6'h04
        |-> next_byte == 8'h1d)
        else $error("Clock answer length low byte wrong");
    AST_FLAGS: assert property (@(posedge pclk)               // see R3
        disable iff (!presetn) push && kind == KIND_CC && idx == 6'h06
        |-> next_byte == {3'h0, valid_flags})
        else $error("Flag byte does not match flag register");
    AST_SECONDS: assert property (@(posedge pclk)             // see R4
        disable iff (!presetn) seconds_into_week <= 32'd604799)
        else $error("Seconds into week above limit");
    AST_ZERO: assert property (@(posedge pclk)                // see R5
        disable iff (!presetn) push && kind == KIND_CC
        && idx >= 6'd13 && idx <= 6'd16 |-> next_byte == 8'h00)
        else $error("Reference offset bytes not zero");
    AST_OFS_FIRST: assert property (@(posedge pclk)           // see R6
        disable iff (!presetn) push && kind == KIND_CC && idx == 6'd17
        |-> next_byte == cc_offset[0][31:24])
        else $error("First offset byte misplaced");
    AST_TERM: assert property (@(posedge pclk)                // see R7
        disable iff (!presetn) push && kind == KIND_CC && idx == 6'd34
        |-> next_byte == 8'h10 ##1 idx == 6'd35 && next_byte == 8'h03)
        else $error("Clock answer terminator wrong");
    AST_AUTO: assert property (@(posedge pclk)                // see R9
        disable iff (!presetn) clk_en && tick && ctrl[0]
        |=> pend_freq || state == ST_SEND)
        else $error("Once-per-second tick lost");
    AST_DAC: assert property (@(posedge pclk)                 // see R11
        disable iff (!presetn) push && kind == KIND_FREQ && idx == 6'd10
        |-> next_byte <= 8'd32)
        else $error("Converter size above 32");
    AST_REF: assert property (@(posedge pclk)                 // see R12
        disable iff (!presetn) push && kind == KIND_FREQ && idx == 6'd52
        |-> next_byte == ref_input)
        else $error("Reference input byte misplaced");
    AST_REFUSE: assert property (@(posedge pclk)              // see R13
        disable iff (!presetn) clk_en && query_cc && !ctrl[1] |=> refused)
        else $error("Refused query not flagged");
endmodule

// ---- sim/host_link.sv ----
/* Host end of the byte link: sends queries, gathers answer bytes.
   Assumes both streams move on pclk. */
`timescale 1ns/1ns
module host_link (
    // Clock
    input  wire logic       pclk,
    // Answer stream
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    // Query stream
    output logic [7:0]      rx_byte,
    output logic            rx_valid
);
    logic [7:0] got[$];
    initial begin
        tx_ready = 1'b0;
        rx_byte  = 8'h00;
        rx_valid = 1'b0;
    end
    // Takes accepted bytes, stalls at random
    always @(posedge pclk) begin
        if (tx_valid && tx_ready)
            got.push_back(tx_data);
        tx_ready <= ($urandom % 4) != 0;
    end
    // Nine-byte query, length two, mode zero
    task automatic send_query(input logic [7:0] s);
        logic [7:0] f[9];
        f = '{8'h10, 8'ha1, s, 8'h00, 8'h02, 8'h00, 8'h5a, 8'h10, 8'h03};
        foreach (f[i]) begin
            @(posedge pclk);
            rx_byte  <= f[i];
            rx_valid <= 1'b1;
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_byte  <= 8'hfc;
    endtask
endmodule

// ---- sim/timing_status_packet_responder_tb.sv ----
/* Bench: answers compared byte by byte with a queue model.
   Assumes the design files and the host link model compile first. */
`timescale 1ns/1ns
`include "responder_defs.svh"
module timing_status_packet_responder_tb;
    logic        pclk, presetn, clk_en, psel, penable, pwrite;
    logic        pready, pslverr, err, tx_valid, tx_ready, rx_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata, fo;
    logic [7:0]  tx_data, rx_byte, c, fl, rf;
    logic [15:0] wk;
    logic [7:0]  exp[$];
    int          n_fail, n_checks, cyc;
    timing_status_packet_responder #(.SECOND_CYCLES(200))
        i_timing_status_packet_responder (.pclk, .presetn, .clk_en, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .rx_byte, .rx_valid, .tx_data, .tx_valid, .tx_ready);
    host_link i_host_link (.pclk, .tx_data, .tx_valid, .tx_ready,
        .rx_byte, .rx_valid);
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic stop_test;
        if (n_fail == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic put(input logic [31:0] v);
        for (int i = 3; i >= 0; i--)
            exp.push_back(v[8*i +: 8]);
    endtask
    task automatic fin;
        c = 8'h00;
        foreach (exp[i]) if (i > 0) c ^= exp[i];
        exp.push_back(c);
        exp.push_back(8'h10);
        exp.push_back(8'h03);
    endtask
    task automatic frame_chk;
        repeat (600) if (i_host_link.got.size() < exp.size()) @(posedge pclk);
        cmp(i_host_link.got.size(), exp.size());
        foreach (exp[i])
            if (i < i_host_link.got.size()) cmp(i_host_link.got[i], exp[i]);
        i_host_link.got.delete();
    endtask
    initial begin
        void'($urandom(32'hce1a3f4a));
        {psel, penable, pwrite, paddr, pwdata} = '0;
        clk_en  = 1'b1;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `REG_CTRL, 32'h0);
        cmp(rdata, 32'h0);
        fl = $urandom;
        wk = $urandom;
        apb(1'b1, `REG_CTRL, 32'h2);
        apb(1'b1, `REG_FLAGS, {24'h0, fl});
        apb(1'b1, `REG_WEEK, {16'h0, wk});
        apb(1'b1, `REG_SECONDS, 32'hffffffff);
        exp = '{8'h10, 8'ha1, 8'h02, 8'h00, 8'h1d, 8'h02, {3'h0, fl[4:0]},
                wk[15:8], wk[7:0]};
        put(`MAX_SECONDS);
        put(32'h0);
        for (int i = 0; i < 4; i++) begin
            fo = $urandom;
            apb(1'b1, 12'(`REG_OFS0 + 4 * i), fo);
            put(fo);
        end
        fin();
        i_host_link.send_query(`SUB_CC);
        frame_chk();
        fo = $urandom;
        rf = $urandom;
        apb(1'b1, `REG_FREQ_OFS, fo);
        apb(1'b1, `REG_DAC_SIZE, 32'h28);
        apb(1'b1, `REG_REF_INPUT, {24'h0, rf});
        exp = '{8'h10, 8'ha1, 8'h03, 8'h00, 8'h31, 8'h02};
        put(fo);
        exp.push_back(8'h20);
        repeat (41) exp.push_back(8'h00);
        exp.push_back(rf);
        fin();
        i_host_link.send_query(`SUB_FREQ);
        frame_chk();
        apb(1'b1, `REG_CTRL, 32'h8);
        frame_chk();
        i_host_link.send_query(`SUB_CC);
        repeat (100) @(posedge pclk);
        cmp(i_host_link.got.size(), 0);
        apb(1'b0, `REG_STATUS, 32'h0);
        cmp(rdata[2], 1'b1);
        apb(1'b1, `REG_CTRL, 32'h4);
        apb(1'b1, `REG_STATUS, 32'h4);
        apb(1'b0, `REG_STATUS, 32'h0);
        cmp(rdata, 32'h300);
        apb(1'b0, 12'h030, 32'h0);
        cmp({err, rdata}, {1'b1, 32'h0});
        apb(1'b1, `REG_CTRL, 32'h1);
        repeat (500) @(posedge pclk);
        apb(1'b1, `REG_CTRL, 32'h0);
        repeat (300) @(posedge pclk);
        fo = i_host_link.got.size();
        cmp(fo, 112);
        cmp(i_host_link.got[54], 8'h10);
        stop_test();
    end
endmodule
